/* File: rtl/pwm_timer_consts.svh */
`ifndef PWM_TIMER_CONSTS_SVH
`define PWM_TIMER_CONSTS_SVH

// ****************************************
// Widths and reset values
// ****************************************
`define CNT_WIDTH        12
`define DT_WIDTH         7
`define CNT_MAX          12'hfff
`define CNT_RESET        12'h000
`define RELOAD_RESET     12'h000
`define DUTY_RESET       12'h000
`define DT_RESET         7'h00
`define CTRL_RESET       4'h0
`define INVERT_RESET     4'h0
`define BREAK_PAT_RESET  4'h0

`endif

/* File: rtl/pwm_timer_pkg.sv */
package pwm_timer_pkg;

    // ****************************************
    // Dead-time sequencer states
    // ****************************************
    typedef enum logic [1:0] {DT_IDLE, DT_WAIT_HIGH0, DT_WAIT_HIGH1} dt_state_type;

endpackage

/* File: rtl/dual_autoreload_pwm_timer.sv */
// What this block does
// - Two free-running 12-bit upcounters, each with its own 12-bit reload value
// - Period is 4096 minus reload value counter-clock ticks
// - Dual-timer enable moves outputs 2 and 3 onto counter 2
// - Duty preloads copy to active duty at overflow when transfer bit set
// - After reset both counters start from zero
// - Overflow drives outputs high; duty match drives them low
// - Polarity bits invert outputs, applied at overflow when transfer bit set
// - Each output gated by its own output enable bit
// - Dead-time enable gives non-overlapping outputs 0 and 1, delay in ticks
// - Dead-time setting buffered and applied after next overflow
// - Dead-time enabled with zero count holds outputs 0 and 1 low before polarity; outputs 2 and 3 keep running
// - Output 0 falls at duty, rises at reload plus dead time; output 1 mirrors
// - Enabled low shutdown pin sets break-active and starts break
// - Software may set break-active directly
// - Break forces pattern, clears and stops counters, reloads, duties, control
// - Clearing break-active hands pins back to the port registers
// - Counter 1 duty match sets compare flag; irq when enabled
// - Compare uses counter 1 only; dual mode compares channels 0 and 1
// - Zero active duty never raises a compare flag
// - Overflow is wrap from maximum count to reload value
`timescale 1ns/100ps
`include "pwm_timer_consts.svh"

module dual_autoreload_pwm_timer
    import pwm_timer_pkg::*;
#(
    parameter int CNT_W = `CNT_WIDTH
)
(
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             count_tick,
    input  wire logic             dual_timer_enable,
    input  wire logic [CNT_W-1:0] reload_value_1,
    input  wire logic [CNT_W-1:0] reload_value_2,
    input  wire logic             reload_write_1,
    input  wire logic             reload_write_2,
    input  wire logic [CNT_W-1:0] duty_value_ch0,
    input  wire logic [CNT_W-1:0] duty_value_ch1,
    input  wire logic [CNT_W-1:0] duty_value_ch2,
    input  wire logic [CNT_W-1:0] duty_value_ch3,
    input  wire logic [3:0]       duty_write,
    input  wire logic             transfer_enable_1,
    input  wire logic             transfer_enable_2,
    input  wire logic [3:0]       invert_ch,
    input  wire logic [3:0]       output_enable_ch,
    input  wire logic             pwm_ctrl_write,
    input  wire logic             dead_time_enable,
    input  wire logic [6:0]       dead_time_count,
    input  wire logic             dead_time_write,
    input  wire logic             shutdown_pin_enable,
    input  wire logic [3:0]       break_pattern,
    input  wire logic             shutdown_n,
    input  wire logic             break_set,
    input  wire logic             break_clear,
    input  wire logic [3:0]       compare_flag_clear,
    input  wire logic             compare_irq_enable,
    input  wire logic [3:0]       port_value,
    output logic [3:0]            wave_out,
    output logic                  break_active,
    output logic [3:0]            compare_flag_ch,
    output logic                  compare_irq,
    output logic [CNT_W-1:0]      up_counter_1,
    output logic [CNT_W-1:0]      up_counter_2
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [CNT_W-1:0]       cnt1;
        logic [CNT_W-1:0]       cnt2;
        logic [CNT_W-1:0]       rel1;
        logic [CNT_W-1:0]       rel2;
        logic [3:0][CNT_W-1:0]  pre;
        logic [3:0][CNT_W-1:0]  act;
        logic [3:0]             inv_act;
        logic [3:0]             oe;
        logic [6:0]             dt_buf;
        logic [6:0]             dt_act;
        logic [6:0]             dt_cnt;
        dt_state_type           dt_state;
        logic [3:0]             raw;
        logic                   brk;
        logic                   was_brk;
        logic [3:0]             cmpf;
        logic [3:0]             out;
        logic                   irq;
    } state_type;

    state_type state_reg;
    state_type state_next;

    // Duty match on counter, zero duty excluded
    function automatic logic match(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] d);
        match = (d != CNT_W'(0)) && (cnt == d);
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        logic       ovf1;
        logic       ovf2;
        logic [3:0] ovf_ch;
        logic [3:0] cmp_hit;
        logic [3:0] gen;
        logic       dt_on;
        logic       dt_zero;
        ovf1 = 1'b0;
        ovf2 = 1'b0;
        ovf_ch = 4'h0;
        cmp_hit = 4'h0;
        gen = 4'h0;
        dt_on = 1'b0;
        dt_zero = 1'b0;
        state_next = state_reg;
        state_next.was_brk = state_reg.brk;

        // Software control writes
        if (reload_write_1)
            state_next.rel1 = reload_value_1;
        if (reload_write_2)
            state_next.rel2 = reload_value_2;
        if (duty_write[0]) state_next.pre[0] = duty_value_ch0;
        if (duty_write[1]) state_next.pre[1] = duty_value_ch1;
        if (duty_write[2]) state_next.pre[2] = duty_value_ch2;
        if (duty_write[3]) state_next.pre[3] = duty_value_ch3;
        if (pwm_ctrl_write)
            state_next.oe = output_enable_ch;
        if (dead_time_write)
            state_next.dt_buf = dead_time_count;

        // Counters and overflow
        if (count_tick && !state_reg.brk)
        begin
            ovf1 = (state_reg.cnt1 == `CNT_MAX);
            ovf2 = (state_reg.cnt2 == `CNT_MAX);
            state_next.cnt1 = ovf1 ? state_reg.rel1 : state_reg.cnt1 + CNT_W'(1);
            state_next.cnt2 = ovf2 ? state_reg.rel2 : state_reg.cnt2 + CNT_W'(1);
        end
        ovf_ch = dual_timer_enable ? {ovf2, ovf2, ovf1, ovf1} : {4{ovf1}};

        // Overflow transfers of duty and polarity
        for (int i = 0; i < 4; i++)
        begin
            if (ovf_ch[i] && ((i < 2 || !dual_timer_enable) ? transfer_enable_1
                                                             : transfer_enable_2))
            begin
                state_next.act[i] = state_reg.pre[i];
                state_next.inv_act[i] = invert_ch[i];
            end
        end
        if (ovf1)
            state_next.dt_act = state_reg.dt_buf;

        // Raw waveforms: high at overflow, low at match
        for (int i = 0; i < 4; i++)
        begin
            if (count_tick && !state_reg.brk)
            begin
                if (ovf_ch[i])
                    state_next.raw[i] = 1'b1;
                else if (match((i >= 2 && dual_timer_enable) ? state_reg.cnt2
                                                             : state_reg.cnt1,
                               state_reg.act[i]))
                    state_next.raw[i] = 1'b0;
            end
        end

        // Dead-time sequencing of channels 0 and 1
        dt_on = dead_time_enable;
        dt_zero = (state_reg.dt_act == `DT_RESET);
        if (count_tick && !state_reg.brk && dt_on)
        begin
            unique case (state_reg.dt_state)
                DT_IDLE:
                begin
                    if (ovf1)
                    begin
                        state_next.dt_state = DT_WAIT_HIGH0;
                        state_next.dt_cnt = state_reg.dt_buf;
                    end
                    else if (match(state_reg.cnt1, state_reg.act[0]))
                    begin
                        state_next.dt_state = DT_WAIT_HIGH1;
                        state_next.dt_cnt = state_reg.dt_act;
                    end
                end
                DT_WAIT_HIGH0, DT_WAIT_HIGH1:
                begin
                    if (state_reg.dt_cnt <= 7'h01)
                        state_next.dt_state = DT_IDLE;
                    else
                        state_next.dt_cnt = state_reg.dt_cnt - 7'h01;
                end
            endcase
        end
        if (!dt_on)
            state_next.dt_state = DT_IDLE;

        if (dt_on)
        begin
            // Out 0: high only after dead time, low from duty match
            gen[0] = state_reg.raw[0] && state_reg.dt_state != DT_WAIT_HIGH0;
            // Out 1: complement, held low during dead time
            gen[1] = !state_reg.raw[0] && state_reg.dt_state != DT_WAIT_HIGH1;
            if (dt_zero)
                gen[1:0] = 2'b00;
        end
        else
            gen[1:0] = state_reg.raw[1:0];
        gen[3:2] = state_reg.raw[3:2];

        // Compare flags, set wins over clear
        for (int i = 0; i < 4; i++)
        begin
            cmp_hit[i] = count_tick && !state_reg.brk
                         && (i < 2 || !dual_timer_enable)
                         && match(state_reg.cnt1, state_reg.act[i]);
            state_next.cmpf[i] = cmp_hit[i] ||
                                 (state_reg.cmpf[i] && !compare_flag_clear[i]);
        end
        state_next.irq = compare_irq_enable && (state_next.cmpf != 4'h0);

        // Break control
        if (break_set || (shutdown_pin_enable && !shutdown_n))
            state_next.brk = 1'b1;
        else if (break_clear)
            state_next.brk = 1'b0;
        if (state_reg.brk)
        begin
            state_next.cnt1 = `CNT_RESET;
            state_next.cnt2 = `CNT_RESET;
            state_next.rel1 = `RELOAD_RESET;
            state_next.rel2 = `RELOAD_RESET;
            state_next.pre = '0;
            state_next.act = '0;
            state_next.oe = `CTRL_RESET;
            state_next.raw = 4'h0;
            state_next.dt_state = DT_IDLE;
        end

        // Output stage: inverter, enable, then break pattern or port
        if (state_reg.brk)
            state_next.out = break_pattern;
        else if (state_reg.was_brk || state_reg.oe == 4'h0)
            state_next.out = port_value;
        else
            for (int i = 0; i < 4; i++)
                state_next.out[i] = state_reg.oe[i] ? (gen[i] ^ state_reg.inv_act[i])
                                                    : port_value[i];
        if (!state_reg.brk && state_reg.was_brk && state_reg.oe == 4'h0)
            state_next.was_brk = 1'b1;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state_reg <= '0;
            state_reg.dt_state <= DT_IDLE;
        end
        else
            state_reg <= state_next;
    end

    assign wave_out = state_reg.out;
    assign break_active = state_reg.brk;
    assign compare_flag_ch = state_reg.cmpf;
    assign compare_irq = state_reg.irq;
    assign up_counter_1 = state_reg.cnt1;
    assign up_counter_2 = state_reg.cnt2;

    // ****************************************
    // Checks
    // ****************************************
    property p_wrap;
        @(posedge ref_clk) disable iff (!rst_n)
        (count_tick && !break_active && up_counter_1 == `CNT_MAX)
        |=> up_counter_1 == $past(state_reg.rel1);
    endproperty
    a_wrap: assert property (p_wrap) else $error("Counter 1 did not reload");

    property p_brk_stop;
        @(posedge ref_clk) disable iff (!rst_n)
        break_active |=> (up_counter_1 == `CNT_RESET && up_counter_2 == `CNT_RESET);
    endproperty
    a_brk_stop: assert property (p_brk_stop) else $error("Counters not cleared");

    property p_brk_pat;
        @(posedge ref_clk) disable iff (!rst_n)
        break_active ##1 break_active |-> wave_out == $past(break_pattern);
    endproperty
    a_brk_pat: assert property (p_brk_pat) else $error("Break pattern not driven");

    property p_pin_brk;
        @(posedge ref_clk) disable iff (!rst_n)
        (shutdown_pin_enable && !shutdown_n) |=> break_active;
    endproperty
    a_pin_brk: assert property (p_pin_brk) else $error("Pin break not taken");

    property p_sticky;
        @(posedge ref_clk) disable iff (!rst_n)
        (break_active && !break_clear) |=> break_active;
    endproperty
    a_sticky: assert property (p_sticky) else $error("Break dropped without clear");

    property p_cmp;
        @(posedge ref_clk) disable iff (!rst_n)
        (count_tick && !break_active && state_reg.act[0] != 12'h000
         && up_counter_1 == state_reg.act[0]) |=> compare_flag_ch[0];
    endproperty
    a_cmp: assert property (p_cmp) else $error("Compare flag not set");

    property p_dual_cmp;
        @(posedge ref_clk) disable iff (!rst_n)
        (dual_timer_enable && !compare_flag_ch[2]) |=> !compare_flag_ch[2];
    endproperty
    a_dual_cmp: assert property (p_dual_cmp) else $error("Dual mode compared ch 2");

    property p_zero_duty;
        @(posedge ref_clk) disable iff (!rst_n)
        (state_reg.act[1] == 12'h000 && !compare_flag_ch[1]) |=> !compare_flag_ch[1];
    endproperty
    a_zero_duty: assert property (p_zero_duty) else $error("Zero duty raised flag");

    property p_dt_zero;
        @(posedge ref_clk) disable iff (!rst_n)
        (dead_time_enable && state_reg.dt_act == 7'h00 && !break_active
         && state_reg.oe[1:0] == 2'b11 && state_reg.inv_act[1:0] == 2'b00 && !state_reg.was_brk)
        |=> wave_out[1:0] == 2'b00;
    endproperty
    a_dt_zero: assert property (p_dt_zero) else $error("Zero dead time not held");

endmodule

/* File: test/half_bridge_stage.sv */
`timescale 1ns/100ps

// ****************************************
// Power stage and shutdown source
// ****************************************
module half_bridge_stage (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] gate_drive,
    input  wire logic       guard_on,
    input  wire logic       trip_req,
    output logic            shutdown_n,
    output logic            overlap_seen
);
    // Trip line pulled high when released
    assign shutdown_n = trip_req ? 1'b0 : 1'b1;

    // Both switches on together
    always @(posedge ref_clk)
    begin
        if (!rst_n)
            overlap_seen <= 1'b0;
        else if (guard_on && (gate_drive == 2'b11))
            overlap_seen <= 1'b1;
    end
endmodule

/* File: test/dual_autoreload_pwm_timer_bench.sv */
`timescale 1ns/100ps

module dual_autoreload_pwm_timer_bench;
    typedef struct {int at; int sel; logic [11:0] mask; logic [11:0] val;} note_type;

    logic        ref_clk, rst_n, dual_timer_enable, transfer_enable_1, transfer_enable_2;
    logic        dead_time_enable, shutdown_pin_enable, compare_irq_enable, trip_req;
    logic        guard_on, shutdown_n, overlap_seen, break_active, compare_irq, count_tick;
    logic [11:0] reload_value_1, reload_value_2, up_counter_1, up_counter_2;
    logic [11:0] duty [4];
    logic [13:0] strobes;
    logic [6:0]  dead_time_count;
    logic [3:0]  invert_ch, output_enable_ch, break_pattern, port_value;
    logic [3:0]  wave_out, compare_flag_ch;
    note_type    notes [$];
    string       what [7] = '{"wave", "break", "flags", "irq", "cnt1", "cnt2", "overlap"};
    int          cyc, bad_count, num_checks;

    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    dual_autoreload_pwm_timer dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .count_tick(count_tick),
        .dual_timer_enable(dual_timer_enable),
        .reload_value_1(reload_value_1), .reload_value_2(reload_value_2),
        .reload_write_1(strobes[0]), .reload_write_2(strobes[1]),
        .duty_value_ch0(duty[0]), .duty_value_ch1(duty[1]),
        .duty_value_ch2(duty[2]), .duty_value_ch3(duty[3]), .duty_write(strobes[9:6]),
        .transfer_enable_1(transfer_enable_1), .transfer_enable_2(transfer_enable_2),
        .invert_ch(invert_ch), .output_enable_ch(output_enable_ch),
        .pwm_ctrl_write(strobes[2]), .dead_time_enable(dead_time_enable),
        .dead_time_count(dead_time_count), .dead_time_write(strobes[3]),
        .shutdown_pin_enable(shutdown_pin_enable), .break_pattern(break_pattern),
        .shutdown_n(shutdown_n), .break_set(strobes[4]), .break_clear(strobes[5]),
        .compare_flag_clear(strobes[13:10]), .compare_irq_enable(compare_irq_enable),
        .port_value(port_value), .wave_out(wave_out), .break_active(break_active),
        .compare_flag_ch(compare_flag_ch), .compare_irq(compare_irq),
        .up_counter_1(up_counter_1), .up_counter_2(up_counter_2)
    );

    half_bridge_stage stage_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .gate_drive(wave_out[1:0]), .guard_on(guard_on),
        .trip_req(trip_req), .shutdown_n(shutdown_n), .overlap_seen(overlap_seen)
    );

    // ****************************************
    // Checking and reporting
    // ****************************************
    task automatic check(string name, logic [11:0] seen, logic [11:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic note(int sel, logic [11:0] mask, logic [11:0] val);
        notes.push_back('{cyc, sel, mask, val});
    endtask

    task automatic wait_n(int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic upto(int which, logic [11:0] v);
        do @(negedge ref_clk); while ((which ? up_counter_2 : up_counter_1) !== v);
    endtask

    task automatic pulse(logic [13:0] m);
        strobes = m;
        wait_n(1);
        strobes = 14'h0000;
    endtask

    always @(negedge ref_clk)
    begin : watch
        note_type    n;
        logic [11:0] seen;
        #1;
        while (notes.size() > 0 && notes[0].at <= cyc)
        begin
            n = notes.pop_front();
            case (n.sel)
                0: seen = {8'h00, wave_out};
                1: seen = {11'h000, break_active};
                2: seen = {8'h00, compare_flag_ch};
                3: seen = {11'h000, compare_irq};
                4: seen = up_counter_1;
                5: seen = up_counter_2;
                default: seen = {11'h000, overlap_seen};
            endcase
            check(what[n.sel], seen & n.mask, n.val);
        end
    end

    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc > 40000)
        begin
            bad_count++;
            conclude();
        end
    end

    // ****************************************
    // Stimulus
    // ****************************************
    initial
    begin
        void'($urandom(26));
        {rst_n, dual_timer_enable, transfer_enable_1, transfer_enable_2} = 4'h0;
        count_tick = 1'b1;
        {dead_time_enable, shutdown_pin_enable, compare_irq_enable, trip_req, guard_on} = 5'h00;
        {reload_value_1, reload_value_2, strobes, dead_time_count} = '0;
        {invert_ch, output_enable_ch, break_pattern, port_value} = 16'h0000;
        duty = '{12'hfe0, 12'hfd0, 12'hff0, 12'hfff};
        wait_n(7);
        note(4, 12'hfff, 12'h000);
        wait_n(1);
        rst_n = 1'b1;
        port_value = 4'($urandom());
        upto(0, 12'h010);
        note(5, 12'hfff, 12'h010);
        note(2, 12'h00f, 12'h000);
        note(0, 12'h00f, {8'h00, port_value});
        reload_value_1 = 12'hfc0;
        reload_value_2 = 12'hfe0;
        {transfer_enable_1, transfer_enable_2, compare_irq_enable} = 3'b111;
        output_enable_ch = 4'hf;
        pulse(14'h03c7);
        upto(0, 12'hfff);
        wait_n(1);
        note(4, 12'hfff, 12'hfc0);
        wait_n(63);
        note(4, 12'hfff, 12'hfff);
        wait_n(1);
        note(4, 12'hfff, 12'hfc0);
        upto(0, 12'hfc8);
        note(0, 12'h00f, 12'h00f);
        upto(0, 12'hfe8);
        note(0, 12'h00f, 12'h00c);
        upto(0, 12'hfc4);
        pulse(14'h3c00);
        upto(0, 12'hfd1);
        note(3, 12'h001, 12'h001);
        count_tick = 1'b0;
        wait_n(5);
        note(4, 12'hfff, 12'hfd1);
        count_tick = 1'b1;
        upto(0, 12'hfc4);
        note(2, 12'h00f, 12'h00f);
        upto(0, 12'hfd0);
        invert_ch = 4'h5;
        upto(0, 12'hfe8);
        note(0, 12'h00f, 12'h00c);
        upto(0, 12'hfc8);
        note(0, 12'h00f, 12'h00a);
        upto(0, 12'hfe8);
        note(0, 12'h00f, 12'h009);
        invert_ch = 4'h0;
        upto(0, 12'hfc8);
        transfer_enable_1 = 1'b0;
        duty[0] = 12'hfd0;
        pulse(14'h0040);
        upto(0, 12'hfd8);
        note(0, 12'h001, 12'h001);
        transfer_enable_1 = 1'b1;
        upto(0, 12'hfd8);
        note(0, 12'h001, 12'h000);
        duty[0] = 12'hfe0;
        output_enable_ch = 4'h5;
        port_value = 4'($urandom());
        pulse(14'h0044);
        wait_n(4);
        note(0, 12'h00f, {8'h00, port_value[3], 1'b1, port_value[1], 1'b0});
        output_enable_ch = 4'hf;
        dead_time_enable = 1'b1;
        dead_time_count = 7'h08;
        pulse(14'h000c);
        upto(0, 12'hfc4);
        guard_on = 1'b1;
        note(0, 12'h003, 12'h000);
        upto(0, 12'hfd8);
        note(0, 12'h00f, 12'h00d);
        upto(0, 12'hff0);
        note(0, 12'h003, 12'h002);
        upto(0, 12'hfd0);
        dead_time_count = 7'h18;
        pulse(14'h0008);
        upto(0, 12'hff4);
        note(0, 12'h002, 12'h002);
        upto(0, 12'hfd0);
        note(0, 12'h003, 12'h000);
        dead_time_count = 7'h00;
        pulse(14'h0008);
        upto(0, 12'hfc4);
        upto(0, 12'hfd8);
        note(0, 12'h003, 12'h000);
        note(6, 12'h001, 12'h000);
        {guard_on, dead_time_enable, dual_timer_enable} = 3'b001;
        upto(0, 12'hfc4);
        pulse(14'h3c00);
        upto(0, 12'hfc4);
        note(2, 12'h00f, 12'h003);
        compare_irq_enable = 1'b0;
        wait_n(2);
        note(3, 12'h001, 12'h000);
        note(2, 12'h00f, 12'h003);
        compare_irq_enable = 1'b1;
        upto(1, 12'hfe8);
        note(0, 12'h004, 12'h004);
        upto(1, 12'hff8);
        note(0, 12'h004, 12'h000);
        transfer_enable_2 = 1'b0;
        duty[2] = 12'hfe8;
        pulse(14'h0100);
        upto(1, 12'hfec);
        note(0, 12'h004, 12'h004);
        transfer_enable_2 = 1'b1;
        upto(1, 12'hfec);
        note(0, 12'h004, 12'h000);
        upto(1, 12'hfff);
        wait_n(1);
        note(5, 12'hfff, 12'hfe0);
        trip_req = 1'b1;
        wait_n(4);
        note(1, 12'h001, 12'h000);
        trip_req = 1'b0;
        break_pattern = 4'($urandom());
        pulse(14'h0010);
        wait_n(4);
        note(1, 12'h001, 12'h001);
        note(0, 12'h00f, {8'h00, break_pattern});
        wait_n(20);
        note(4, 12'hfff, 12'h000);
        note(5, 12'hfff, 12'h000);
        pulse(14'h0020);
        {shutdown_pin_enable, trip_req} = 2'b11;
        wait_n(2);
        trip_req = 1'b0;
        wait_n(10);
        note(1, 12'h001, 12'h001);
        port_value = 4'($urandom());
        pulse(14'h0020);
        wait_n(4);
        note(1, 12'h001, 12'h000);
        note(0, 12'h00f, {8'h00, port_value});
        pulse(14'h3c00);
        upto(0, 12'hfff);
        wait_n(1);
        note(4, 12'hfff, 12'h000);
        note(2, 12'h00f, 12'h000);
        wait_n(2);
        conclude();
    end
endmodule
